// >>> src/scc_pkg.sv
// Package: register map, field positions, modes and counts for the clock source control
package scc_pkg;
    // Word-aligned Wishbone byte addresses
    localparam logic [3:0] SCC_ADDR_MULT = 4'h0;
    localparam logic [3:0] SCC_ADDR_OSC  = 4'h4;
    localparam logic [3:0] SCC_ADDR_CFG  = 4'h8;
    // Field positions
    localparam int SCC_BIT_MULT_EN   = 6;
    localparam int SCC_BIT_IDLE      = 7;
    localparam int SCC_BIT_PRI_READY = 3;
    localparam int SCC_BIT_SRC_HI    = 1;
    localparam int SCC_BIT_SRC_LO    = 0;
    // Reset values
    localparam logic       SCC_MULT_EN_RST = 1'b0;
    localparam logic       SCC_IDLE_RST    = 1'b0;
    localparam logic [1:0] SCC_SRC_RST     = 2'b00;
    // Clock source field codes
    localparam logic [1:0] SCC_SRC_DEFAULT = 2'b00;
    localparam logic [1:0] SCC_SRC_SEC     = 2'b01;
    localparam logic [1:0] SCC_SRC_PRI     = 2'b10;
    localparam logic [1:0] SCC_SRC_INT     = 2'b11;
    // Cycle counts, clock rates in MHz and the multiplier factor
    localparam int SCC_OLD_CYCLES   = 2;
    localparam int SCC_NEW_CYCLES   = 3;
    localparam int SCC_STARTUP_CNT  = 1024;
    localparam int SCC_CLK_MHZ      = 10;
    localparam int SCC_MAX_MULT_MHZ = 40;
    localparam int SCC_MULT_FACTOR  = 4;

    typedef enum logic [1:0] {
        SCC_MODE_CRYSTAL     = 2'b00,
        SCC_MODE_CRYSTAL_MUL = 2'b01,
        SCC_MODE_EXT         = 2'b10,
        SCC_MODE_EXT_MUL     = 2'b11
    } scc_mode_type;

    typedef enum logic [1:0] {
        SCC_ST_RUN  = 2'b00,
        SCC_ST_OLD  = 2'b01,
        SCC_ST_NEW  = 2'b10
    } scc_sw_type;
endpackage

// >>> src/scc_clk_switch.sv
// Glitch-free switch sequencer: stops old source, then waits on the new one
`timescale 1ns/10ps
`default_nettype none
module scc_clk_switch
    import scc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic [1:0] req_src_i,
    input  wire logic       old_tick_i,
    input  wire logic       new_tick_i,
    output logic [1:0]      cur_src_o,
    output logic            gate_o,
    output logic            busy_o
);
    scc_sw_type st_r;
    scc_sw_type st_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [1:0] cur_r;
    logic [1:0] cur_nxt;
    wire        change_w   = (req_src_i != cur_r);
    wire        old_done_w = old_tick_i && (cnt_r == 3'(SCC_OLD_CYCLES - 1));
    wire        new_done_w = new_tick_i && (cnt_r == 3'(SCC_NEW_CYCLES - 1));

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        cur_nxt = cur_r;
        unique case (st_r)
            SCC_ST_RUN: begin
                if (change_w) begin
                    st_nxt  = SCC_ST_OLD;
                    cnt_nxt = 3'h0;
                end
            end
            SCC_ST_OLD: begin
                if (old_done_w) begin
                    st_nxt  = SCC_ST_NEW;
                    cnt_nxt = 3'h0;
                    cur_nxt = req_src_i;
                end else if (old_tick_i) begin
                    cnt_nxt = cnt_r + 3'h1;
                end
            end
            SCC_ST_NEW: begin
                if (new_done_w) begin
                    st_nxt = SCC_ST_RUN;
                end else if (new_tick_i) begin
                    cnt_nxt = cnt_r + 3'h1;
                end
            end
            default: begin
                st_nxt = SCC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            st_r  <= SCC_ST_RUN;
            cnt_r <= 3'h0;
            cur_r <= SCC_SRC_RST;
        end else if (ce_i) begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            cur_r <= cur_nxt;
        end
    end

    // Output held low during the whole switch so no runt pulse escapes
    assign gate_o    = (st_r == SCC_ST_RUN);
    assign busy_o    = (st_r != SCC_ST_RUN);
    assign cur_src_o = cur_r;

    property p_pause_two_old;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (st_r == SCC_ST_RUN && change_w && ce_i) |=> !gate_o [*2];
    endproperty
    a_pause_two_old: assert property (p_pause_two_old) else $error("Gate opened too soon");

    property p_gate_static;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (st_r == SCC_ST_OLD) |-> !gate_o;
    endproperty
    a_gate_static: assert property (p_gate_static) else $error("Gate open during switch");
endmodule
`default_nettype wire

// >>> src/scc_top.sv
// Top: clock source control registers, source selection and pin behaviour
// Contract
// - Five oscillator modes: crystal, crystal x4, external, external x4, internal.
// - External modes come from config bits; internal selectable by software or default.
// - External clock modes skip the oscillator start-up wait.
// - External mode without multiplier drives quarter-rate clock on output pin.
// - Crystal mode never produces the quarter-rate output.
// - Multiplier modes with multiplier on run at four times source, 40 MHz max.
// - Multiplier enable is bit 6 of multiplier register, reset zero, read-write.
// - Outside multiplier modes the enable bit reads zero; other bits read zero.
// - Internal oscillator runs at power-up until configuration is loaded.
// - Internal oscillator runs when selected or monitor, watchdog, two-speed enabled.
// - Source field: 11 internal, 10 primary, 01 secondary.
// - Source 00 means primary if default bit one, else internal.
// - Every reset clears the source field.
// - Writing the source field switches the clock after a short transition.
// - Switch pauses two old-source cycles plus three new-source cycles.
// - Primary-ready flag bit 3 is one after start-up timer expires; here, after config load, it reads one only while primary is the active source.
// - Start-up timer counts 1024 oscillator cycles before crystal use; here it only delays the ready flag, the switch to primary does not wait for it.
// - Primary-ready resets zero with crystal plus two-speed, else one.
// - At most one of primary-ready and secondary-running set.
// - Idle bit 7: sleep enters idle when set, full sleep when clear.
// - Selecting secondary at sleep is ignored unless secondary oscillator enabled.
// - Oscillator control bits 6..4 and 2 read zero.
`timescale 1ns/10ps
`default_nettype none
module scc_top
    import scc_pkg::*;
#(
    parameter int STARTUP_CYCLES = SCC_STARTUP_CNT
)
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Configuration and system inputs
    input  wire logic        cfg_loaded_i,
    input  wire logic        default_source_config_bit_i,
    input  wire logic [1:0]  primary_mode_config_bits_i,
    input  wire logic        two_speed_en_i,
    input  wire logic        fail_safe_en_i,
    input  wire logic        watchdog_en_i,
    input  wire logic        secondary_oscillator_enable_i,
    input  wire logic        sleep_exec_i,
    input  wire logic        oscillator_input_pin_i,
    input  wire logic        pri_osc_tick_i,
    input  wire logic        sec_osc_tick_i,
    input  wire logic        int_osc_tick_i,
    // Clock selection outputs
    output logic [1:0]       active_src_o,
    output logic             clk_gate_o,
    output logic             switching_o,
    output logic             multiplier_on_o,
    output logic             internal_osc_run_o,
    output logic             primary_ready_flag_o,
    output logic             secondary_running_flag_o,
    output logic             idle_mode_o,
    output logic             sleep_mode_o,
    output logic             oscillator_output_pin_o
);
    logic       mult_en_r;
    logic       idle_r;
    logic [1:0] src_r;
    logic       pri_ready_r;
    logic [10:0] start_cnt_r;
    logic [1:0] div_r;
    logic       osc_in_d_r;
    logic       loaded_r;
    logic       idle_mode_r;
    logic       sleep_mode_r;
    logic       ack_r;
    logic [31:0] dat_r;

    // Latched configuration; sampled once loading completes
    scc_mode_type mode_r;
    logic         dflt_r;

    wire req_w     = wb_cyc_i && wb_stb_i && !ack_r;
    wire wr_w      = req_w && wb_we_i && wb_sel_i[0];
    wire wr_mult_w = wr_w && (wb_adr_i == SCC_ADDR_MULT);
    wire wr_osc_w  = wr_w && (wb_adr_i == SCC_ADDR_OSC);

    wire mul_mode_w = (mode_r == SCC_MODE_CRYSTAL_MUL) || (mode_r == SCC_MODE_EXT_MUL);
    wire ext_mode_w = (mode_r == SCC_MODE_EXT) || (mode_r == SCC_MODE_EXT_MUL);
    wire xtal_w     = (mode_r == SCC_MODE_CRYSTAL) || (mode_r == SCC_MODE_CRYSTAL_MUL);

    // Field 00 folds onto primary or internal by the default bit
    wire [1:0] eff_src_w = (src_r != SCC_SRC_DEFAULT) ? src_r :
                           (dflt_r ? SCC_SRC_PRI : SCC_SRC_INT);
    // Until config is loaded the internal oscillator owns the clock
    wire [1:0] req_src_w = loaded_r ? eff_src_w : SCC_SRC_INT;

    // Secondary stays refused while its oscillator is off, so a sleep never lands on it
    wire sec_block_w = (req_src_w == SCC_SRC_SEC)
                       && !secondary_oscillator_enable_i;
    wire [1:0] sel_src_w = sec_block_w ? active_src_o : req_src_w;

    wire old_tick_w = (active_src_o == SCC_SRC_PRI) ? pri_osc_tick_i :
                      (active_src_o == SCC_SRC_SEC) ? sec_osc_tick_i : int_osc_tick_i;
    wire new_tick_w = (sel_src_w == SCC_SRC_PRI) ? pri_osc_tick_i :
                      (sel_src_w == SCC_SRC_SEC) ? sec_osc_tick_i : int_osc_tick_i;

    scc_clk_switch u_switch (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .req_src_i  (sel_src_w),
        .old_tick_i (old_tick_w),
        .new_tick_i (new_tick_w),
        .cur_src_o  (active_src_o),
        .gate_o     (clk_gate_o),
        .busy_o     (switching_o)
    );

    wire pri_rst_w   = !(xtal_w && two_speed_en_i);
    wire start_end_w = (start_cnt_r == 11'(STARTUP_CYCLES - 1));
    wire osc_rise_w  = oscillator_input_pin_i && !osc_in_d_r;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mult_en_r <= SCC_MULT_EN_RST;
            idle_r    <= SCC_IDLE_RST;
            src_r     <= SCC_SRC_RST;
        end else if (ce_i) begin
            if (wr_mult_w && mul_mode_w) begin
                mult_en_r <= wb_dat_i[SCC_BIT_MULT_EN];
            end
            if (wr_osc_w) begin
                idle_r <= wb_dat_i[SCC_BIT_IDLE];
                src_r  <= wb_dat_i[SCC_BIT_SRC_HI:SCC_BIT_SRC_LO];
            end
        end
    end

    // Configuration capture after reset release, never under reset itself
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            loaded_r <= 1'b0;
            mode_r   <= SCC_MODE_CRYSTAL;
            dflt_r   <= 1'b1;
        end else if (ce_i && cfg_loaded_i && !loaded_r) begin
            loaded_r <= 1'b1;
            mode_r   <= scc_mode_type'(primary_mode_config_bits_i);
            dflt_r   <= default_source_config_bit_i;
        end
    end

    // Start-up wait only for crystal modes; external clocks are ready at once
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            pri_ready_r <= 1'b0;
            start_cnt_r <= 11'h000;
        end else if (ce_i) begin
            if (!loaded_r) begin
                pri_ready_r <= 1'b0;
                start_cnt_r <= 11'h000;
            end else if (ext_mode_w || pri_rst_w && start_cnt_r == 11'h000 && !pri_ready_r
                         && !xtal_w) begin
                pri_ready_r <= 1'b1;
            end else if (!pri_ready_r && pri_osc_tick_i) begin
                if (start_end_w) begin
                    pri_ready_r <= 1'b1;
                end else begin
                    start_cnt_r <= start_cnt_r + 11'h001;
                end
            end
        end
    end

    // Quarter-rate output from the input clock, only in plain external mode
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            div_r      <= 2'b00;
            osc_in_d_r <= 1'b0;
        end else if (ce_i) begin
            osc_in_d_r <= oscillator_input_pin_i;
            if (osc_rise_w) begin
                div_r <= div_r + 2'b01;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            idle_mode_r  <= 1'b0;
            sleep_mode_r <= 1'b0;
        end else if (ce_i && sleep_exec_i) begin
            idle_mode_r  <= idle_r;
            sleep_mode_r <= !idle_r;
        end
    end

    // Wishbone: answer one cycle after the request, unmapped reads return zero
    wire [31:0] rd_mult_w = {24'h000000, 1'b0, mult_en_r && mul_mode_w, 6'h00};
    wire [31:0] rd_osc_w  = {24'h000000, idle_r, 3'h0, primary_ready_flag_o, 1'b0, src_r};
    wire [31:0] rd_cfg_w  = {24'h000000, 3'h0, loaded_r, dflt_r, 1'b0, mode_r};
    wire [31:0] rd_w      = (wb_adr_i == SCC_ADDR_MULT) ? rd_mult_w :
                            (wb_adr_i == SCC_ADDR_OSC)  ? rd_osc_w  :
                            (wb_adr_i == SCC_ADDR_CFG)  ? rd_cfg_w  : 32'h00000000;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else if (ce_i) begin
            ack_r <= req_w;
            dat_r <= rd_w;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    // Crystal modes never drive the quarter-rate pin
    assign oscillator_output_pin_o = (loaded_r && mode_r == SCC_MODE_EXT) ? div_r[1] : 1'b0;
    assign multiplier_on_o = mul_mode_w && mult_en_r;
    assign internal_osc_run_o = !loaded_r || (active_src_o == SCC_SRC_INT)
                                || (sel_src_w == SCC_SRC_INT)
                                || fail_safe_en_i || watchdog_en_i || two_speed_en_i;
    // After config load primary reads ready only while it is the running source, keeping one flag at most
    assign primary_ready_flag_o = loaded_r ? (pri_ready_r && active_src_o == SCC_SRC_PRI)
                                           : pri_rst_w;
    assign secondary_running_flag_o = (active_src_o == SCC_SRC_SEC) && clk_gate_o
                                      && !primary_ready_flag_o;
    assign idle_mode_o  = idle_mode_r;
    assign sleep_mode_o = sleep_mode_r;

    property p_src_reset;
        @(posedge core_clk_i) !nrst_i |=> (src_r == SCC_SRC_RST);
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("Source field not cleared");

    property p_mult_zero;
        @(posedge core_clk_i) disable iff (!nrst_i) !mul_mode_w |-> rd_mult_w == 32'h0;
    endproperty
    a_mult_zero: assert property (p_mult_zero) else $error("Multiplier bit visible");

    property p_osc_pin;
        @(posedge core_clk_i) disable iff (!nrst_i) xtal_w |-> !oscillator_output_pin_o;
    endproperty
    a_osc_pin: assert property (p_osc_pin) else $error("Quarter-rate on crystal");

    property p_one_flag;
        @(posedge core_clk_i) disable iff (!nrst_i)
        !(primary_ready_flag_o && secondary_running_flag_o);
    endproperty
    a_one_flag: assert property (p_one_flag) else $error("Both status flags set");

    property p_ext_ready;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (loaded_r && ext_mode_w && ce_i) |=> pri_ready_r;
    endproperty
    a_ext_ready: assert property (p_ext_ready) else $error("External mode waited");

    property p_default_sel;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (loaded_r && src_r == SCC_SRC_DEFAULT && !dflt_r) |-> req_src_w == SCC_SRC_INT;
    endproperty
    a_default_sel: assert property (p_default_sel) else $error("Default source wrong");

    property p_ack_once;
        @(posedge core_clk_i) disable iff (!nrst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("Ack held");

    property p_int_run;
        @(posedge core_clk_i) disable iff (!nrst_i) watchdog_en_i |-> internal_osc_run_o;
    endproperty
    a_int_run: assert property (p_int_run) else $error("Internal osc stopped");

    // Write fields, named for the checks below
    wire [1:0] wr_src_w  = wb_dat_i[SCC_BIT_SRC_HI:SCC_BIT_SRC_LO];
    wire       wr_idle_w = wb_dat_i[SCC_BIT_IDLE];

    sequence s_switch_begin;
        !switching_o && (sel_src_w != active_src_o) && ce_i;
    endsequence

    property p_switch_start;
        @(posedge core_clk_i) disable iff (!nrst_i)
        s_switch_begin |=> switching_o;
    endproperty
    a_switch_start: assert property (p_switch_start) else $error("Switch not started");

    property p_src_write;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr_osc_w && ce_i) |=> (src_r == $past(wr_src_w));
    endproperty
    a_src_write: assert property (p_src_write) else $error("Source write lost");

    property p_idle_write;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr_osc_w && ce_i) |=> (idle_r == $past(wr_idle_w));
    endproperty
    a_idle_write: assert property (p_idle_write) else $error("Idle write lost");

    property p_mult_hold;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr_mult_w && !mul_mode_w && ce_i) |=> $stable(mult_en_r);
    endproperty
    a_mult_hold: assert property (p_mult_hold) else $error("Multiplier bit written");

    property p_sleep_kind;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (sleep_exec_i && ce_i) |=> (idle_mode_o == $past(idle_r)) && (sleep_mode_o != idle_mode_o);
    endproperty
    a_sleep_kind: assert property (p_sleep_kind) else $error("Sleep kind wrong");

    property p_cfg_kept;
        @(posedge core_clk_i) disable iff (!nrst_i)
        loaded_r |=> ($stable(mode_r) && $stable(dflt_r));
    endproperty
    a_cfg_kept: assert property (p_cfg_kept) else $error("Config changed after load");

    property p_startup_hold;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (loaded_r && xtal_w && !pri_ready_r && !start_end_w) |=> !pri_ready_r;
    endproperty
    a_startup_hold: assert property (p_startup_hold) else $error("Start-up cut short");

    property p_sec_refused;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (sec_block_w && active_src_o != SCC_SRC_SEC) |=> (active_src_o != SCC_SRC_SEC);
    endproperty
    a_sec_refused: assert property (p_sec_refused) else $error("Secondary taken while off");

    property p_no_load_int;
        @(posedge core_clk_i) disable iff (!nrst_i)
        !loaded_r |-> (sel_src_w == SCC_SRC_INT);
    endproperty
    a_no_load_int: assert property (p_no_load_int) else $error("Source before load");
endmodule
`default_nettype wire

// >>> dv/scc_osc_model.sv
// Oscillator model: primary, secondary and internal ticks plus external clock pin
`timescale 1ns/10ps
`default_nettype none
module scc_osc_model #(
    parameter int PRI_DIV = 3,
    parameter int SEC_DIV = 5,
    parameter int INT_DIV = 7
)
(
    input  wire logic core_clk_i,
    output logic      pri_tick_o,
    output logic      sec_tick_o,
    output logic      int_tick_o,
    output logic      ext_pin_o
);
    int         pri_cnt = 0;
    int         sec_cnt = 0;
    int         int_cnt = 0;
    logic [1:0] phase_r = 2'h0;
    initial begin
        pri_tick_o = 1'b0;
        sec_tick_o = 1'b0;
        int_tick_o = 1'b0;
        ext_pin_o  = 1'b0;
    end
    // Ticks are slower than the core clock so each source phase is visible
    always @(posedge core_clk_i) begin
        pri_cnt    <= (pri_cnt + 1) % PRI_DIV;
        pri_tick_o <= (pri_cnt == 0);
        // Secondary runs all the time, so a switch to it never waits on start-up
        sec_cnt    <= (sec_cnt + 1) % SEC_DIV;
        sec_tick_o <= (sec_cnt == 0);
        int_cnt    <= (int_cnt + 1) % INT_DIV;
        int_tick_o <= (int_cnt == 0);
        // External clock has a period of four core cycles
        phase_r    <= phase_r + 2'h1;
        ext_pin_o  <= phase_r[1];
    end
endmodule
`default_nettype wire

// >>> dv/tb_scc_top.sv
// Testbench for the clock source control block
`timescale 1ns/10ps
`default_nettype none
module tb_scc_top;
    import scc_pkg::*;
    localparam int STARTUP = 32;
    logic        core_clk_i, nrst_i, wb_cyc, wb_stb, wb_we, cfg_ld, dflt, two_spd, fs_en, wd_en;
    logic        sec_en, sleep_x, pin, pri_t, sec_t, int_t, wb_ack_o, gate, swg, mul_on, int_run;
    logic        pri_rdy, sec_run, idle_m, sleep_m, out_pin;
    logic [1:0]  mode, act;
    logic [3:0]  wb_adr;
    logic [31:0] wb_dat, wb_dat_o, q;
    int          err_total = 0;
    int          cmp_count = 0;
    scc_osc_model i_scc_osc_model (.core_clk_i(core_clk_i), .pri_tick_o(pri_t),
        .sec_tick_o(sec_t), .int_tick_o(int_t), .ext_pin_o(pin));
    scc_top #(.STARTUP_CYCLES(STARTUP)) i_scc_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .ce_i(1'b1), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cfg_loaded_i(cfg_ld), .default_source_config_bit_i(dflt),
        .primary_mode_config_bits_i(mode), .two_speed_en_i(two_spd), .fail_safe_en_i(fs_en),
        .watchdog_en_i(wd_en), .secondary_oscillator_enable_i(sec_en), .sleep_exec_i(sleep_x),
        .oscillator_input_pin_i(pin), .pri_osc_tick_i(pri_t), .sec_osc_tick_i(sec_t),
        .int_osc_tick_i(int_t), .active_src_o(act), .clk_gate_o(gate), .switching_o(swg),
        .multiplier_on_o(mul_on), .internal_osc_run_o(int_run),
        .primary_ready_flag_o(pri_rdy), .secondary_running_flag_o(sec_run),
        .idle_mode_o(idle_m), .sleep_mode_o(sleep_m), .oscillator_output_pin_o(out_pin));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 50) begin
            err_total++;
            tally_and_finish();
        end
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk("read data", exp, q);
    endtask
    task automatic settle;
        int n;
        repeat (3) @(posedge core_clk_i);
        for (n = 0; n < 200 && swg !== 1'b0; n++) @(posedge core_clk_i);
        if (n == 200) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic boot(input logic [1:0] m, input logic d, input logic ts);
        @(posedge core_clk_i);
        nrst_i  <= 1'b0;
        cfg_ld  <= 1'b0;
        mode    <= m;
        dflt    <= d;
        two_spd <= ts;
        repeat (16) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        settle();
        chk("src before load", 32'h3, {30'h0, act});
        cfg_ld <= 1'b1;
        settle();
    endtask
    task automatic sw(input logic [1:0] code, input logic [1:0] exp);
        int n;
        int lowc;
        lowc = 0;
        wb(1'b1, SCC_ADDR_OSC, {30'h0, code});
        for (n = 0; n < 300; n++) begin
            @(posedge core_clk_i);
            if (gate === 1'b0) lowc++;
            if (n > 4 && swg === 1'b0) break;
        end
        chk("active src", {30'h0, exp}, {30'h0, act});
        chk("gate paused", 32'h1, {31'h0, lowc >= 5});
    endtask
    task automatic t_regs;
        boot(SCC_MODE_EXT_MUL, 1'b1, 1'b0);
        rd_chk(SCC_ADDR_MULT, 32'h0);
        rd_chk(SCC_ADDR_OSC, 32'h8);
        rd_chk(4'hc, 32'h0);
        rd_chk(SCC_ADDR_CFG, 32'h1b);
        chk("default src", 32'h2, {30'h0, act});
        wb(1'b1, SCC_ADDR_MULT, 32'hff);
        rd_chk(SCC_ADDR_MULT, 32'h40);
        chk("mult on", 32'h1, {31'h0, mul_on});
        boot(SCC_MODE_CRYSTAL, 1'b1, 1'b0);
        wb(1'b1, SCC_ADDR_MULT, 32'h40);
        rd_chk(SCC_ADDR_MULT, 32'h0);
        chk("mult off", 32'h0, {31'h0, mul_on});
    endtask
    task automatic t_switch;
        boot(SCC_MODE_EXT, 1'b1, 1'b0);
        wb(1'b1, SCC_ADDR_OSC, 32'h1);
        sleep_x <= 1'b1;
        @(posedge core_clk_i);
        sleep_x <= 1'b0;
        repeat (40) @(posedge core_clk_i);
        chk("sec refused", 32'h2, {30'h0, act});
        wb(1'b1, SCC_ADDR_OSC, 32'h0);
        sec_en <= 1'b1;
        sw(SCC_SRC_INT, 2'h3);
        sw(SCC_SRC_SEC, 2'h1);
        chk("status flags", 32'h1, {30'h0, pri_rdy, sec_run});
        sw(SCC_SRC_PRI, 2'h2);
        sw(SCC_SRC_INT, 2'h3);
        sw(SCC_SRC_DEFAULT, 2'h2);
        wb(1'b1, SCC_ADDR_OSC, 32'h7e);
        rd_chk(SCC_ADDR_OSC, 32'ha);
        wd_en <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk("internal run", 32'h1, {31'h0, int_run});
        wd_en <= 1'b0;
        fs_en <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk("internal run", 32'h1, {31'h0, int_run});
        fs_en <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        chk("internal idle", 32'h0, {31'h0, int_run});
        boot(SCC_MODE_EXT, 1'b0, 1'b0);
        chk("default src", 32'h3, {30'h0, act});
    endtask
    task automatic t_startup;
        int n;
        boot(SCC_MODE_CRYSTAL, 1'b1, 1'b1);
        rd_chk(SCC_ADDR_OSC, 32'h0);
        chk("internal run", 32'h1, {31'h0, int_run});
        for (n = 0; n < 200 && pri_rdy !== 1'b1; n++) @(posedge core_clk_i);
        chk("startup long", 32'h1, {31'h0, n >= STARTUP + 16});
        rd_chk(SCC_ADDR_OSC, 32'h8);
    endtask
    task automatic quarter(input logic [1:0] m, input int lo, input int hi);
        int c;
        logic prev;
        c = 0;
        boot(m, 1'b1, 1'b0);
        prev = out_pin;
        repeat (64) begin
            @(posedge core_clk_i);
            if (out_pin === 1'b1 && prev === 1'b0) c++;
            prev = out_pin;
        end
        chk("quarter edges", 32'h1, {31'h0, c >= lo && c <= hi});
    endtask
    task automatic t_sleep(input logic [31:0] w);
        int n;
        wb(1'b1, SCC_ADDR_OSC, w);
        sleep_x <= 1'b1;
        @(posedge core_clk_i);
        sleep_x <= 1'b0;
        for (n = 0; n < 8 && (w[7] ? idle_m : sleep_m) !== 1'b1; n++) @(posedge core_clk_i);
        chk("sleep kind", {31'h0, w[7]}, {31'h0, idle_m});
        chk("sleep full", {31'h0, !w[7]}, {31'h0, sleep_m});
    endtask
    initial begin
        {nrst_i, wb_cyc, wb_stb, wb_we, cfg_ld, dflt, two_spd, fs_en, wd_en} = '0;
        {sec_en, sleep_x, mode, wb_adr, wb_dat} = '0;
        t_regs();
        t_switch();
        t_startup();
        quarter(SCC_MODE_EXT, 3, 5);
        quarter(SCC_MODE_CRYSTAL, 0, 0);
        t_sleep(32'h80);
        t_sleep(32'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
